// file: rtl/tick_timers.sv
`timescale 1ns/1ps
module tick_timers (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic                       por,
	input  wire tick_timers_pkg::reg_req_t  req,
	input  wire logic                       privileged_mode_flag,
	input  wire logic                       global_interrupt_enable,
	input  wire logic [3:0]                 current_priority_level,
	input  wire logic                       perf_wrap,
	input  wire logic                       sys_tick_in,
	output tick_timers_pkg::reg_rsp_t       rsp,
	output logic [15:1]                     irq_level,
	output logic                            take_irq,
	output logic [3:0]                      take_level
);
	import tick_timers_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [PEND_W-1:0] pending_interrupts;
	logic [63:0]       cycle_match;
	logic [63:0]       system_time_counter;
	logic [63:0]       system_time_match;
	logic [62:0]       cycle_count;
	logic [2:0]        tick_sync;
	logic              cyc_eq_q;
	logic              sys_eq_q;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire priv     = privileged_mode_flag;
	wire hit_set  = req.addr == OFF_SET;
	wire hit_clr  = req.addr == OFF_CLEAR;
	wire hit_pend = req.addr == OFF_PENDING;
	wire hit_ccmp = req.addr == OFF_CYC_CMP;
	wire hit_scnt = req.addr == OFF_SYS_CNT;
	wire hit_scmp = req.addr == OFF_SYS_CMP;
	wire acc      = req.rd | req.wr;
	wire bad_port = acc & (hit_set | hit_clr | hit_pend) & ~priv;
	wire bad_cmp  = acc & (hit_ccmp | hit_scmp) & ~priv;
	wire bad_swr  = req.wr & hit_scnt & ~priv;
	wire bad_srd  = req.rd & hit_scnt & ~priv & system_time_counter[BIT_DIS];
	wire refuse   = bad_port | bad_cmp | bad_swr | bad_srd;
	wire wr_ok    = req.wr & ~refuse;
	wire rd_ok    = req.rd & ~refuse;

	// edge of synchronised tick; first stage only feeds second
	wire tick_edge = tick_sync[1] & ~tick_sync[2];

	wire cyc_eq = ~cycle_match[BIT_DIS] & (cycle_match[62:0] == cycle_count);
	wire sys_eq = ~system_time_match[BIT_DIS]
		& (system_time_match[62:0] == system_time_counter[62:0]);
	// post only on the rising edge of equality
	wire cyc_post = cyc_eq & ~cyc_eq_q;
	wire sys_post = sys_eq & ~sys_eq_q;

	// events set; set wins over clear in the same cycle
	logic [PEND_W-1:0] hw_set;
	always_comb begin
		hw_set = '0;
		hw_set[BIT_CYC] = cyc_post;
		hw_set[BIT_SYS] = sys_post;
		hw_set[BIT_PERF] = perf_wrap;
	end

	wire [PEND_W-1:0] wval = req.wdata[PEND_W-1:0];
	logic [PEND_W-1:0] next_pending;
	always_comb begin
		next_pending = pending_interrupts;
		if (wr_ok && hit_pend) begin
			next_pending = wval;
		end else if (wr_ok && hit_set) begin
			next_pending = pending_interrupts | wval;
		end else if (wr_ok && hit_clr) begin
			next_pending = pending_interrupts & ~wval;
		end
		next_pending = next_pending | hw_set;
	end

	// fold timer sources onto level 14
	wire [15:1] lvl_req = {pending_interrupts[15],
		pending_interrupts[14] | pending_interrupts[BIT_SYS] | pending_interrupts[BIT_CYC],
		pending_interrupts[13:1]};

	logic [3:0] top_lvl;
	always_comb begin
		top_lvl = 4'h0;
		// each bit is its own level
		for (int i = 1; i < 16; i++) begin
			if (lvl_req[i]) begin
				top_lvl = 4'(i);
			end
		end
	end
	wire next_take = global_interrupt_enable & (top_lvl > current_priority_level);

	logic [63:0] rd_mux;
	always_comb begin
		rd_mux = 64'h0000000000000000;
		if (hit_pend) begin
			rd_mux = {47'h0, pending_interrupts};
		end else if (hit_ccmp) begin
			rd_mux = cycle_match;
		end else if (hit_scnt) begin
			rd_mux = system_time_counter;
		end else if (hit_scmp) begin
			rd_mux = system_time_match;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		tick_sync <= {tick_sync[1:0], sys_tick_in};
	end

	// counter and compares reset only by power-on
	always_ff @(posedge clk) begin
		if (por) begin
			cycle_match         <= CMP_RST;
			system_time_match   <= CMP_RST;
			system_time_counter <= SYS_RST;
		end else begin
			if (wr_ok && hit_ccmp) begin
				cycle_match <= req.wdata;
			end
			if (wr_ok && hit_scmp) begin
				system_time_match <= req.wdata;
			end
			// write replaces count, counting resumes from it
			if (wr_ok && hit_scnt) begin
				system_time_counter <= req.wdata;
			end else if (tick_edge) begin
				system_time_counter[62:0] <= system_time_counter[62:0] + 63'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || por) begin
			pending_interrupts <= '0;
			cycle_count        <= '0;
			cyc_eq_q           <= 1'b0;
			sys_eq_q           <= 1'b0;
			rsp                <= '0;
			irq_level          <= '0;
			take_irq           <= 1'b0;
			take_level         <= 4'h0;
		end else begin
			pending_interrupts <= next_pending;
			cycle_count        <= cycle_count + 63'h1;
			cyc_eq_q           <= cyc_eq;
			sys_eq_q           <= sys_eq;
			rsp.done           <= acc;
			rsp.priv_opcode    <= bad_port | bad_cmp | bad_swr;
			rsp.priv_action    <= bad_srd;
			rsp.rdata          <= rd_ok ? rd_mux : 64'h0000000000000000;
			irq_level          <= lvl_req;
			take_irq           <= next_take;
			take_level         <= next_take ? top_lvl : 4'h0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || por);

	// ------------------------------------------------------------
	// checks: register access
	// ------------------------------------------------------------

	a_set_port_or: assert property (
		wr_ok && hit_set |=> (pending_interrupts & $past(wval)) == $past(wval))
		else $error("set port did not set bits");

	a_set_exact: assert property (
		wr_ok && hit_set |=> pending_interrupts
		== ($past(pending_interrupts) | $past(wval) | $past(hw_set)))
		else $error("set port changed other bits");

	a_clear_port: assert property (
		wr_ok && hit_clr && !perf_wrap && !cyc_post && !sys_post
		|=> (pending_interrupts & $past(wval)) == '0)
		else $error("clear port did not clear bits");

	a_clear_keep: assert property (
		wr_ok && hit_clr |=> pending_interrupts
		== (($past(pending_interrupts) & ~$past(wval)) | $past(hw_set)))
		else $error("clear port changed other bits");

	a_port_user_trap: assert property (
		acc && (hit_set || hit_clr) && !priv |=> rsp.priv_opcode)
		else $error("user port access not trapped");

	a_port_rdata: assert property (
		rd_ok && (hit_set || hit_clr) |=> rsp.rdata == 64'h0000000000000000)
		else $error("write-only port returned data");

	a_port_no_write: assert property (
		acc && (hit_set || hit_clr || hit_pend) && !priv
		|=> pending_interrupts == ($past(pending_interrupts) | $past(hw_set)))
		else $error("user access changed pending");

	a_pend_write: assert property (
		wr_ok && hit_pend |=> pending_interrupts == ($past(wval) | $past(hw_set)))
		else $error("pending write lost");

	a_pend_read: assert property (
		rd_ok && hit_pend |=> rsp.rdata == {47'h0, $past(pending_interrupts)})
		else $error("pending read wrong");

	a_done_pulse: assert property (
		1'b1 |=> rsp.done == $past(acc))
		else $error("done not one cycle after access");

	a_cmp_user_trap: assert property (
		acc && (hit_ccmp || hit_scmp) && !priv |=> rsp.priv_opcode && rsp.rdata == 0)
		else $error("user compare access not trapped");

	a_cmp_no_write: assert property (
		req.wr && (hit_ccmp || hit_scmp) && !priv
		|=> $stable(cycle_match) && $stable(system_time_match))
		else $error("user write changed compare");

	a_cyc_cmp_load: assert property (
		wr_ok && hit_ccmp |=> cycle_match == $past(req.wdata))
		else $error("cycle compare write lost");

	a_sys_cmp_load: assert property (
		wr_ok && hit_scmp |=> system_time_match == $past(req.wdata))
		else $error("system compare write lost");

	a_cnt_load: assert property (
		wr_ok && hit_scnt |=> system_time_counter == $past(req.wdata))
		else $error("counter write lost");

	a_npt_read_trap: assert property (
		req.rd && hit_scnt && !priv && system_time_counter[63] |=> rsp.priv_action)
		else $error("user read not trapped");

	a_user_read_ok: assert property (
		req.rd && hit_scnt && !priv && !system_time_counter[BIT_DIS]
		|=> !rsp.priv_action && !rsp.priv_opcode)
		else $error("allowed user read trapped");

	a_priv_cnt_ok: assert property (
		acc && hit_scnt && priv |=> !rsp.priv_action && !rsp.priv_opcode)
		else $error("privileged counter access trapped");

	a_user_wr_block: assert property (
		req.wr && hit_scnt && !priv && !tick_edge
		|=> system_time_counter == $past(system_time_counter))
		else $error("user write changed counter");

	// ------------------------------------------------------------
	// checks: counting and reset
	// ------------------------------------------------------------

	a_tick_step: assert property (
		tick_edge && !(wr_ok && hit_scnt)
		|=> system_time_counter[62:0] == $past(system_time_counter[62:0]) + 63'h1)
		else $error("counter did not step by one");

	a_trap_bit_kept: assert property (
		!(wr_ok && hit_scnt)
		|=> system_time_counter[BIT_DIS] == $past(system_time_counter[BIT_DIS]))
		else $error("trap bit changed by counting");

	a_cycle_count: assert property (
		1'b1 |=> cycle_count == $past(cycle_count) + 63'h1)
		else $error("cycle counter did not step");

	a_por_cyc_cmp: assert property (
		disable iff (1'b0) por |=> cycle_match == CMP_RST)
		else $error("cycle compare reset value wrong");

	a_por_sys_cmp: assert property (
		disable iff (1'b0) por |=> system_time_match == CMP_RST)
		else $error("system compare reset value wrong");

	a_por_counter: assert property (
		disable iff (1'b0) por |=> system_time_counter == SYS_RST)
		else $error("counter reset value wrong");

	a_sys_rst_keep: assert property (
		disable iff (por) sys_rst && !acc && !tick_edge
		|=> $stable(system_time_counter) && $stable(cycle_match) && $stable(system_time_match))
		else $error("plain reset disturbed time state");

	// ------------------------------------------------------------
	// checks: posting and interrupts
	// ------------------------------------------------------------

	a_cyc_match_post: assert property (
		cyc_post |=> pending_interrupts[BIT_CYC] ##1 irq_level[14])
		else $error("cycle match not posted");

	a_sys_match_post: assert property (
		sys_post |=> pending_interrupts[BIT_SYS] ##1 irq_level[14])
		else $error("system match not posted");

	a_cyc_disabled: assert property (
		cycle_match[BIT_DIS] |-> !cyc_post)
		else $error("disabled cycle compare posted");

	a_sys_disabled: assert property (
		system_time_match[BIT_DIS] |-> !sys_post)
		else $error("disabled system compare posted");

	a_cyc_kept: assert property (
		pending_interrupts[BIT_CYC] && !(wr_ok && (hit_clr || hit_pend))
		|=> pending_interrupts[BIT_CYC])
		else $error("cycle bit dropped");

	a_sys_kept: assert property (
		pending_interrupts[BIT_SYS] && !(wr_ok && (hit_clr || hit_pend))
		|=> pending_interrupts[BIT_SYS])
		else $error("system bit dropped");

	a_perf_wrap_post: assert property (
		perf_wrap |=> pending_interrupts[BIT_PERF])
		else $error("overflow not posted");

	a_perf_level: assert property (
		perf_wrap |-> ##2 irq_level[15])
		else $error("overflow level not raised");

	a_irq_level: assert property (
		1'b1 |=> irq_level[13:1] == $past(pending_interrupts[13:1]))
		else $error("level request wrong");

	a_lvl_share: assert property (
		1'b1 |=> irq_level[14] == ($past(pending_interrupts[14])
		|| $past(pending_interrupts[BIT_SYS]) || $past(pending_interrupts[BIT_CYC]))
		&& irq_level[15] == $past(pending_interrupts[15]))
		else $error("shared level wrong");

	a_take_gate: assert property (
		take_irq |-> $past(global_interrupt_enable)
		&& take_level > $past(current_priority_level))
		else $error("interrupt taken while masked");

	a_take_open: assert property (
		next_take |=> take_irq && take_level == $past(top_lvl))
		else $error("interrupt not taken");

	a_take_closed: assert property (
		!next_take |=> !take_irq && take_level == 4'h0)
		else $error("interrupt shown while closed");

	c_cyc_match: cover property (cyc_post);
	c_sys_match: cover property (sys_post);
	c_npt_trap: cover property (bad_srd);
	c_take: cover property (take_irq && take_level == LVL_TIMER);
	c_user_wr: cover property (bad_swr);
endmodule

// file: rtl/tick_timers_pkg.sv
// Operation
// - set port ORs bits 16:0 into pending
// - clear port clears pending bits 16:0
// - set/clear ports privileged, write-only
// - pending register privileged read/write
// - system time match sets bit 16
// - bits 15:1 request their own level
// - level 14 is shared
// - cycle match sets bit 0
// - user access to compares traps
// - cycle counter counts processor clocks
// - cycle compare resets disabled, zero
// - cycle compare layout, match posts bit
// - interrupt only when level above current priority, enabled
// - 63-bit system counter, bit 63 trap
// - user read traps when trap bit set
// - user write of system counter traps
// - power-on sets trap bit, clears counter
// - reads advance from last written value
// - only power-on reset affects counter
// - system compare resets disabled, zero
// - system compare layout, match posts bit
// - performance counter wrap sets bit 15
package tick_timers_pkg;
	localparam logic [4:0] OFF_SET     = 5'h14;
	localparam logic [4:0] OFF_CLEAR   = 5'h15;
	localparam logic [4:0] OFF_PENDING = 5'h16;
	localparam logic [4:0] OFF_CYC_CMP = 5'h17;
	localparam logic [4:0] OFF_SYS_CNT = 5'h18;
	localparam logic [4:0] OFF_SYS_CMP = 5'h19;
	localparam int         PEND_W      = 17;
	localparam int         BIT_DIS     = 63;
	localparam int         BIT_SYS     = 16;
	localparam int         BIT_CYC     = 0;
	localparam int         BIT_PERF    = 15;
	localparam logic [3:0] LVL_TIMER   = 4'hE;
	localparam logic [63:0] CMP_RST    = 64'h8000000000000000;
	localparam logic [63:0] SYS_RST    = 64'h8000000000000000;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  addr;
		logic [63:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        done;
		logic        priv_opcode;
		logic        priv_action;
		logic [63:0] rdata;
	} reg_rsp_t;
endpackage

// file: sim/tick_timers_bench.sv
`timescale 1ns/1ps
module tick_timers_bench;
	import tick_timers_pkg::*;
	logic        clk = 0, sys_rst = 1, por = 1, pv = 1, gie = 0, pw = 0, tk = 0;
	logic [3:0]  cpl = 4'h0;
	reg_req_t    req = '0;
	reg_rsp_t    rsp, r;
	logic [15:1] irq_level;
	logic        take_irq;
	logic [3:0]  take_level;
	int          num_errors = 0, checks_done = 0;
	logic [31:0] st = 32'h000060D7;
	logic [63:0] pend, v, d;
	logic [63:0] dis = 64'h8000000000000000;
	always #2 clk = ~clk;
	tick_timers tick_timers_inst (.clk(clk), .sys_rst(sys_rst), .por(por), .req(req),
		.privileged_mode_flag(pv), .global_interrupt_enable(gie),
		.current_priority_level(cpl), .perf_wrap(pw), .sys_tick_in(tk), .rsp(rsp),
		.irq_level(irq_level), .take_irq(take_irq), .take_level(take_level));
	function automatic logic [31:0] xs();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction
	// level 14 carries the shared sources
	function automatic logic [15:1] lvl(input logic [63:0] p);
		return p[15:1] | {1'b0, p[16] | p[0], 13'h0000};
	endfunction
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// request held for one edge, answer awaited under a bound
	task automatic acc(input logic w, input logic [4:0] a, input logic [63:0] dd, input logic p);
		@(posedge clk);
		req <= '{rd: !w, wr: w, addr: a, wdata: dd};
		pv <= p;
		@(posedge clk);
		req <= '0;
		#1;
		for (int i = 0; i < 4 && rsp.done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		r = rsp;
		pv <= 1'b1;
		chk("done", 64'h1, r.done);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [63:0] e, input logic p);
		acc(1'b0, a, 64'h0, p);
		chk("rdata", e, r.rdata);
	endtask
	// slow external clock, parked low between bursts
	task automatic ticks(input int n);
		repeat (n * 2) begin
			repeat (4) @(posedge clk);
			tk <= ~tk;
		end
		repeat (8) @(posedge clk);
	endtask
	task automatic irqc(input logic [63:0] p);
		logic [15:1] l;
		logic [3:0]  hi;
		l = lvl(p);
		hi = 4'h0;
		repeat (3) @(posedge clk);
		#1;
		for (int k = 1; k < 16; k++) if (l[k]) hi = k[3:0];
		chk("irq_level", l, irq_level);
		chk("take_irq", gie && hi > cpl, take_irq);
		chk("take_level", (gie && hi > cpl) ? hi : 4'h0, take_level);
	endtask
	task final_report;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#80000;
		num_errors++;
		final_report;
	end
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 0;
		por <= 0;
		// ----------------------------------------
		// reset values and refusals
		// ----------------------------------------
		rdc(OFF_CYC_CMP, dis, 1);
		rdc(OFF_SYS_CMP, dis, 1);
		rdc(OFF_SYS_CNT, dis, 1);
		rdc(OFF_PENDING, 64'h0, 1);
		for (int a = 20; a < 26; a++) begin
			acc(1'b0, a[4:0], 64'h0, 1'b0);
			chk("opcode", a != 24, r.priv_opcode);
			chk("action", a == 24, r.priv_action);
			chk("rdata", 64'h0, r.rdata);
			acc(1'b1, a[4:0], 64'h0, 1'b0);
			chk("opcode", 64'h1, r.priv_opcode);
		end
		rdc(OFF_SYS_CNT, dis, 1);
		rdc(OFF_CYC_CMP, dis, 1);
		rdc(OFF_SET, 64'h0, 1);
		rdc(5'h03, 64'h0, 1);
		pend = 64'h0;
		for (int i = 0; i < 24; i++) begin
			d = (i < 2) ? '1 : {xs(), xs()};
			acc(1'b1, 5'(OFF_SET + i % 3), d, 1'b1);
			if (i % 3 == 0) pend = pend | {47'h0, d[16:0]};
			else if (i % 3 == 1) pend = pend & ~{47'h0, d[16:0]};
			else pend = {47'h0, d[16:0]};
			v = {xs(), xs()};
			gie <= v[4];
			cpl <= v[3:0];
			rdc(OFF_PENDING, pend, 1);
			irqc(pend);
		end
		// ----------------------------------------
		// system time counter and its match
		// ----------------------------------------
		acc(1'b1, OFF_PENDING, 64'h0, 1'b1);
		v = {xs(), xs()};
		v[63:62] = 2'h0;
		acc(1'b1, OFF_SYS_CNT, v, 1'b1);
		acc(1'b1, OFF_SYS_CMP, v + 3, 1'b1);
		ticks(3);
		rdc(OFF_SYS_CNT, v + 3, 0);
		pend = 64'h10000;
		rdc(OFF_PENDING, pend, 1);
		gie <= 1;
		cpl <= 4'hD;
		irqc(pend);
		cpl <= 4'hE;
		irqc(pend);
		acc(1'b1, OFF_CLEAR, 64'h10000, 1'b1);
		rdc(OFF_PENDING, 64'h0, 1);
		ticks(1);
		acc(1'b1, OFF_SYS_CMP, dis, 1'b1);
		acc(1'b1, OFF_CYC_CMP, 64'h28, 1'b1);
		@(posedge clk);
		sys_rst <= 1;
		@(posedge clk);
		sys_rst <= 0;
		repeat (60) @(posedge clk);
		rdc(OFF_PENDING, 64'h1, 1);
		rdc(OFF_SYS_CNT, v + 4, 1);
		@(posedge clk);
		pw <= 1;
		@(posedge clk);
		pw <= 0;
		pend = 64'h8001;
		rdc(OFF_PENDING, pend, 1);
		cpl <= 4'h0;
		irqc(pend);
		final_report;
	end
endmodule
